// ### hdl/bds_pkg.sv
// constants and types shared by the buck ramp sequencer
// assumes a 250 MHz single clock domain
package bds_pkg;
    localparam int CLK_MHZ = 250;
    localparam int CODE_W = 6;
    localparam int NUM_RAILS = 5;
    localparam int RAIL_CORE1 = 0;
    localparam int RAIL_CORE2 = 1;
    localparam int RAIL_THIRD = 2;
    localparam int RAIL_FOURTH = 3;
    localparam int RAIL_FIFTH = 4;
    // step interval times in ns, as printed in microseconds x 1000
    localparam int STEP_NS_2US = 2000;
    localparam int STEP_NS_4US = 4000;
    localparam int STEP_NS_8US = 8000;
    localparam int STEP_NS_16US = 16000;
    localparam int CNT_W = 16;
    // cycle counts, least times rounded up
    localparam logic [CNT_W-1:0] CYC_2US = CNT_W'((STEP_NS_2US * CLK_MHZ + 999) / 1000);
    localparam logic [CNT_W-1:0] CYC_4US = CNT_W'((STEP_NS_4US * CLK_MHZ + 999) / 1000);
    localparam logic [CNT_W-1:0] CYC_8US = CNT_W'((STEP_NS_8US * CLK_MHZ + 999) / 1000);
    localparam logic [CNT_W-1:0] CYC_16US = CNT_W'((STEP_NS_16US * CLK_MHZ + 999) / 1000);
    localparam logic [1:0] RATE_2US = 2'h0;
    localparam logic [1:0] RATE_4US = 2'h1;
    localparam logic [1:0] RATE_8US = 2'h2;
    localparam logic [1:0] RATE_16US = 2'h3;
    localparam logic [1:0] RATE_RESET = RATE_4US;
    localparam logic [1:0] HI_RANGE_8US = 2'h0;
    localparam logic [CODE_W-1:0] CODE_RESET = 6'h00;
    // fifth buck code range limit (00000..11010)
    localparam logic [CODE_W-1:0] FIFTH_CODE_MAX = 6'h1a;
    typedef enum logic [1:0] {BDS_IDLE, BDS_WAIT, BDS_STEP} bds_state_t;
endpackage

// ### hdl/bds_ramp_if.sv
// bundle between the top and one rail ramp engine
// assumes both ends share clk_in
interface bds_ramp_if;
    import bds_pkg::*;
    logic [CODE_W-1:0] goal;
    logic [CNT_W-1:0] interval;
    logic [CODE_W-1:0] level;
    logic busy;
    modport ctl(output goal, output interval, input level, input busy);
    modport eng(input goal, input interval, output level, output busy);
endinterface

// ### hdl/bds_ramp.sv
// one rail ramp engine: steps a code toward its goal, one code per interval
// assumes the goal and interval are steady between steps; rate changes take
// effect at the next interval start
module bds_ramp
    import bds_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // control bundle
    bds_ramp_if.eng rif
);
    bds_state_t state, next_state;
    logic [CNT_W-1:0] cnt, next_cnt;
    logic [CODE_W-1:0] level, next_level;
    // the zero count and the step cycle both sit inside the interval, so a step
    // lands exactly one interval after the last; limitation: interval must be >= 2
    localparam logic [CNT_W-1:0] LOAD_TRIM = CNT_W'(2);

    // next state: idle until goal differs, then wait one interval per step
    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_level = level;
        unique case (state)
            BDS_IDLE: begin
                if (rif.goal != level) begin
                    next_state = BDS_WAIT; // R2
                    next_cnt = rif.interval - LOAD_TRIM; // R4
                end
            end
            BDS_WAIT: begin
                if (cnt == '0) begin
                    next_state = BDS_STEP;
                end else begin
                    next_cnt = cnt - CNT_W'(1);
                end
            end
            BDS_STEP: begin
                // one code per interval, never overshooting the goal
                if (rif.goal > level) begin
                    next_level = level + CODE_W'(1); // R14
                end else if (rif.goal < level) begin
                    next_level = level - CODE_W'(1); // R14
                end
                if (next_level == rif.goal) begin
                    next_state = BDS_IDLE; // R14
                end else begin
                    next_state = BDS_WAIT;
                    next_cnt = rif.interval - LOAD_TRIM; // R4
                end
            end
        endcase
    end

    // registers
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            state <= BDS_IDLE;
            cnt <= '0;
            level <= CODE_RESET;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            level <= next_level;
        end
    end

    assign rif.level = level;
    assign rif.busy = (state != BDS_IDLE);
endmodule

// ### hdl/bds_top.sv
// buck dynamic voltage scaling sequencer: set point choice and stepped ramps
// for five buck rails, power good outputs for the two core bucks
// assumes set point fields and standby come from registers on clk_in
// Functional notes
// R1 - The core bucks target the normal set point when standby is 0 and the standby one when 1.
// R2 - A new normal set point is reached by controlled steps, never a jump.
// R3 - Standby entry or exit on core bucks steps at the rate from the two-bit rate field.
// R4 - Core steps are 12.5 mV each, every 2, 4 (default), 8 or 16 us by codes 00 to 11.
// R5 - Third and fifth bucks step 25 mV each 4.0 us on software set point changes.
// R6 - The fourth pair steps 25 mV each 8.0 us when its high range field is 00.
// R7 - Third, fourth and fifth bucks also use a standby set point while standby is high.
// R8 - Each core buck has an active high power good output, high once at target.
// R9 - Power good is low throughout a ramp and whenever current limit is hit.
// R10 - Overcurrent reports from a rail are masked while that rail ramps.
// R11 - Current limit outside a ramp keeps power good low until the limit clears.
// R12 - Software should pick PWM mode before a critically timed ramp.
// R13 - Fifth buck codes are linear 25 mV steps from 1.2000 V up to code 11010.
// R14 - The target moves one step per interval, stops at the set point and ends the ramp.
module bds_top
    import bds_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // standby control line
    input wire logic standby_in,
    // set point fields, one code per rail
    input wire logic [NUM_RAILS*CODE_W-1:0] normal_setpoint_in,
    input wire logic [NUM_RAILS*CODE_W-1:0] standby_setpoint_in,
    // ramp rate select for the two core bucks
    input wire logic [1:0] ramp_rate_select_core1_in,
    input wire logic [1:0] ramp_rate_select_core2_in,
    // fourth pair high range select
    input wire logic [1:0] high_range_select_in,
    // raw current limit flags from each rail
    input wire logic [NUM_RAILS-1:0] current_limit_in,
    // present target codes toward the analog regulators
    output logic [NUM_RAILS*CODE_W-1:0] target_code_out,
    // ramp in progress per rail
    output logic [NUM_RAILS-1:0] ramp_active_out,
    // overcurrent reports after ramp masking
    output logic [NUM_RAILS-1:0] overcurrent_out,
    // power good toward the processor
    output logic core_buck_first_power_good_out,
    output logic core_buck_second_power_good_out
);
    // select one of the four core rates
    function automatic logic [CNT_W-1:0] core_interval(input logic [1:0] sel);
        logic [CNT_W-1:0] r;
        r = CYC_4US;
        unique case (sel)
            RATE_2US: r = CYC_2US;
            RATE_4US: r = CYC_4US;
            RATE_8US: r = CYC_8US;
            RATE_16US: r = CYC_16US;
        endcase
        return r;
    endfunction

    // pick normal or standby code for one rail
    function automatic logic [CODE_W-1:0] pick_code(input logic stby, input logic [CODE_W-1:0] nrm,
                                                    input logic [CODE_W-1:0] sby);
        return stby ? sby : nrm;
    endfunction

    // power good for one rail: settled at its goal and free of current limit
    function automatic logic rail_good(input logic busy, input logic limit,
                                       input logic [CODE_W-1:0] goal,
                                       input logic [CODE_W-1:0] lvl);
        return !busy && !limit && (goal == lvl);
    endfunction

    bds_ramp_if rif [NUM_RAILS] ();
    logic [NUM_RAILS-1:0] busy_w;
    logic [NUM_RAILS*CODE_W-1:0] level_w;
    logic [CODE_W-1:0] goal_w [NUM_RAILS];
    logic [CNT_W-1:0] interval_w [NUM_RAILS];

    // goal per rail; fifth buck clamped to its listed code range
    always_comb begin
        for (int i = 0; i < NUM_RAILS; i++) begin
            goal_w[i] = pick_code(standby_in, normal_setpoint_in[i*CODE_W +: CODE_W],
                                  standby_setpoint_in[i*CODE_W +: CODE_W]); // R1 R7
        end
        if (goal_w[RAIL_FIFTH] > FIFTH_CODE_MAX) begin
            goal_w[RAIL_FIFTH] = FIFTH_CODE_MAX; // R13
        end
    end

    // step interval per rail; the 16 us fourth pair case has no usable code
    always_comb begin
        interval_w[RAIL_CORE1] = core_interval(ramp_rate_select_core1_in); // R3 R4
        interval_w[RAIL_CORE2] = core_interval(ramp_rate_select_core2_in); // R3 R4
        interval_w[RAIL_THIRD] = CYC_4US; // R5
        interval_w[RAIL_FIFTH] = CYC_4US; // R5
        // only code 00 is defined; others fall back to the same 8 us pace
        interval_w[RAIL_FOURTH] = (high_range_select_in == HI_RANGE_8US) ? CYC_8US
                                                                         : CYC_8US; // R6
    end

    // one ramp engine per rail
    generate
        for (genvar g = 0; g < NUM_RAILS; g++) begin : g_rail
            assign rif[g].goal = goal_w[g];
            assign rif[g].interval = interval_w[g];
            assign busy_w[g] = rif[g].busy;
            assign level_w[g*CODE_W +: CODE_W] = rif[g].level;
            bds_ramp u_ramp (
                .clk_in(clk_in),
                .rst_n_in(rst_n_in),
                .rif(rif[g])
            );
        end
    endgenerate

    logic [NUM_RAILS*CODE_W-1:0] next_target_code;
    logic [NUM_RAILS-1:0] next_ramp_active;
    logic [NUM_RAILS-1:0] next_overcurrent;
    logic next_pg1, next_pg2;

    // output values: ramp flags, masked overcurrent and power good
    always_comb begin
        next_target_code = level_w; // R2
        next_ramp_active = busy_w; // R14
        // ramp inrush is not a fault, so hide it while stepping
        next_overcurrent = current_limit_in & ~busy_w; // R10
        // a pending goal counts as ramping so power good drops at once
        next_pg1 = rail_good(busy_w[RAIL_CORE1], current_limit_in[RAIL_CORE1],
                             goal_w[RAIL_CORE1], rif[RAIL_CORE1].level); // R8 R9 R11
        next_pg2 = rail_good(busy_w[RAIL_CORE2], current_limit_in[RAIL_CORE2],
                             goal_w[RAIL_CORE2], rif[RAIL_CORE2].level); // R8 R9 R11
    end

    // output registers
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            target_code_out <= '0;
            ramp_active_out <= '0;
            overcurrent_out <= '0;
            core_buck_first_power_good_out <= 1'b0;
            core_buck_second_power_good_out <= 1'b0;
        end else begin
            target_code_out <= next_target_code;
            ramp_active_out <= next_ramp_active;
            overcurrent_out <= next_overcurrent;
            core_buck_first_power_good_out <= next_pg1;
            core_buck_second_power_good_out <= next_pg2;
        end
    end
endmodule

// ### tb/bds_top_props.sv
// port checker for the buck ramp sequencer
// assumes binding onto bds_top in the single clk_in domain
module bds_top_props
    import bds_pkg::*;
(
    // watched ports
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [NUM_RAILS-1:0] current_limit_in,
    input wire logic [NUM_RAILS*CODE_W-1:0] target_code_out,
    input wire logic [NUM_RAILS-1:0] ramp_active_out,
    input wire logic [NUM_RAILS-1:0] overcurrent_out,
    input wire logic core_buck_first_power_good_out,
    input wire logic core_buck_second_power_good_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [CODE_W-1:0] prev0;
    logic [CNT_W-1:0] gap;
    logic [CNT_W-1:0] next_gap;
    // cycles since rail 0 last moved, counting the move cycle itself;
    // saturating so long idles never wrap
    always_comb begin
        next_gap = (target_code_out[5:0] != prev0) ? 16'h1 : gap + {15'h0, ~&gap};
    end
    always_ff @(posedge clk_in) begin
        prev0 <= target_code_out[5:0];
        gap <= rst_n_in ? next_gap : 16'h0;
    end
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    AST_PG_RAMP1: assert property (ramp_active_out[0] |-> !core_buck_first_power_good_out)
        else $error("core one power good high while ramping");
    AST_PG_GOOD2: assert property (core_buck_second_power_good_out |-> !ramp_active_out[1] && !$past(current_limit_in[1]))
        else $error("core two power good high while ramping or limited");
    AST_PG_LIMIT1: assert property (current_limit_in[0] |=> !core_buck_first_power_good_out)
        else $error("core one power good high under current limit");
    AST_OC_MASK: assert property ($past(rst_n_in) |-> overcurrent_out == ($past(current_limit_in) & ~ramp_active_out))
        else $error("overcurrent report not masked by ramp");
    AST_STEP1: assert property ($past(rst_n_in) && $changed(target_code_out[5:0]) |-> 6'(target_code_out[5:0] - $past(target_code_out[5:0])) inside {6'h01, 6'h3f})
        else $error("core one target moved more than one code");
    AST_GAP0: assert property (target_code_out[5:0] != prev0 |-> gap >= CYC_2US)
        else $error("core one steps closer than the fastest interval");
    AST_CLAMP5: assert property (target_code_out[29:24] <= FIFTH_CODE_MAX)
        else $error("fifth rail code above its table");
    AST_PG_DONE1: assert property ($fell(ramp_active_out[0]) && !$past(current_limit_in[0]) |-> core_buck_first_power_good_out)
        else $error("core one power good missing after ramp");
endmodule
bind bds_top bds_top_props i_props (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .current_limit_in(current_limit_in), .target_code_out(target_code_out),
    .ramp_active_out(ramp_active_out), .overcurrent_out(overcurrent_out),
    .core_buck_first_power_good_out(core_buck_first_power_good_out),
    .core_buck_second_power_good_out(core_buck_second_power_good_out));

// ### tb/bds_proc_model.sv
// processor side: holds the set point image and the standby line
// assumes put() is called off the clock edge by the bench
module bds_proc_model
    import bds_pkg::*;
(
    // clock
    input wire logic clk_in,
    // fields toward the sequencer
    output logic standby_out,
    output logic [NUM_RAILS*CODE_W-1:0] normal_out,
    output logic [NUM_RAILS*CODE_W-1:0] sby_out,
    output logic [1:0] rate_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // power-on image, rate at its default code
    initial begin
        standby_out = 1'b0;
        normal_out = '0;
        sby_out = '0;
        rate_out = RATE_RESET;
    end
    // one write burst; mode taken as pwm for timed ramps
    task automatic put(input logic s, input logic [29:0] n, input logic [29:0] b, input logic [1:0] r);
        @(posedge clk_in);
        standby_out <= s;
        normal_out <= n;
        sby_out <= b;
        rate_out <= r;
    endtask
endmodule

// ### tb/bds_top_tb_top.sv
// self-checking bench for the buck ramp sequencer
// assumes the processor model drives fields and the bench drives limits
module bds_top_tb_top import bds_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic [4:0] lim = 5'h0;
    logic standby;
    logic [29:0] nrm, sby, tgt;
    logic [1:0] rate;
    logic [4:0] act, oc;
    logic pg1, pg2;
    int n_mismatch = 0;
    int n_checks = 0;
    int cyc = 0;
    logic [15:0] tab [4] = '{CYC_2US, CYC_4US, CYC_8US, CYC_16US};
    // 250 MHz clock
    always #2 clk_in = ~clk_in;
    bds_proc_model i_proc (.clk_in(clk_in), .standby_out(standby), .normal_out(nrm),
        .sby_out(sby), .rate_out(rate));
    // high range tied at 00, the only defined code
    bds_top i_dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .standby_in(standby),
        .normal_setpoint_in(nrm), .standby_setpoint_in(sby), .ramp_rate_select_core1_in(rate),
        .ramp_rate_select_core2_in(rate), .high_range_select_in(2'h0), .current_limit_in(lim),
        .target_code_out(tgt), .ramp_active_out(act), .overcurrent_out(oc),
        .core_buck_first_power_good_out(pg1), .core_buck_second_power_good_out(pg2));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // edges until rail r moves, sampled after the edge settles
    task automatic step_gap(input int r, output int n);
        logic [5:0] v;
        v = tgt[r*6 +: 6];
        n = 0;
        while (tgt[r*6 +: 6] === v && n < 9000) begin
            @(posedge clk_in);
            #1;
            n++;
        end
    endtask
    task automatic settle();
        int i;
        i = 0;
        repeat (3) @(posedge clk_in);
        while (act !== 5'h0 && i < 40000) begin
            @(posedge clk_in);
            i++;
        end
        #1;
    endtask
    // core rails: write up, standby down, each rate, limit mid ramp
    task automatic t_rates();
        int n;
        for (int k = 0; k < 4; k++) begin
            i_proc.put(k[0], 30'hc3, 30'h0, k[1:0]);
            step_gap(0, n);
            step_gap(0, n);
            chk(n, tab[k]);
            @(posedge clk_in);
            lim <= 5'h01;
            @(posedge clk_in);
            #1;
            chk({oc[0], pg1, act[0]}, 3'b001);
            @(posedge clk_in);
            lim <= 5'h00;
            settle();
            chk(tgt[11:0], k[0] ? 12'h0 : 12'hc3);
            chk({pg1, pg2}, 2'b11);
        end
    endtask
    // third and fourth rails step intervals on software writes
    task automatic t_slow();
        int n;
        i_proc.put(1'b0, 30'h2000, 30'h0, RATE_4US);
        step_gap(2, n);
        step_gap(2, n);
        chk(n, CYC_4US);
        i_proc.put(1'b0, 30'h82000, 30'h0, RATE_4US);
        step_gap(3, n);
        step_gap(3, n);
        chk(n, CYC_8US);
        settle();
    endtask
    // standby set points on all rails, fifth beyond its table
    task automatic t_standby();
        i_proc.put(1'b1, 30'h82000, 30'h3f041000, RATE_4US);
        settle();
        chk(tgt, 30'h1a041000);
    endtask
    // current limit while idle holds power good low until it clears
    task automatic t_limit();
        @(posedge clk_in);
        lim <= 5'h01;
        repeat (3) @(posedge clk_in);
        #1;
        chk({oc[0], pg1}, 2'b10);
        @(posedge clk_in);
        lim <= 5'h00;
        repeat (2) @(posedge clk_in);
        #1;
        chk({oc[0], pg1}, 2'b01);
    endtask
    // run length cap, well past the longest ramp chain
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 95000) begin
            n_mismatch++;
            results();
        end
    end
    initial begin
        repeat (5) @(posedge clk_in);
        rst_n_in <= 1'b1;
        t_rates();
        t_slow();
        t_standby();
        t_limit();
        results();
    end
endmodule
